// ==== rtl/dram_ctl_pkg.sv ====
package dram_ctl_pkg;

  localparam int ROW_W         = 6;
  localparam int COL_W         = 6;
  localparam int ADDR_W        = ROW_W + COL_W;
  localparam int ROW_COUNT     = 64;
  localparam int INIT_REFRESH  = 8;
  localparam int SYNC_STAGES   = 2;
  localparam int CNT_W         = 9;
  localparam int TMR_W         = 11;
  localparam int INIT_W        = 4;

  // times in ns as the part states them; the clock period is 25 ns
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_RCD_NS      = 50;
  localparam int T_CAC_NS      = 165;
  localparam int T_RAS_NS      = 250;
  localparam int T_RAS_MAX_NS  = 10000;
  localparam int T_RP_NS       = 150;
  localparam int T_CP_NS       = 110;
  localparam int T_REFRESH_NS  = 2000000;

  // least times round up, longest times round down
  localparam int RCD_CYC     = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAC_CYC     = (T_CAC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAS_CYC     = (T_RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RP_CYC      = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CP_CYC      = (T_CP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAS_MAX_CYC = T_RAS_MAX_NS / CLK_PERIOD_NS;
  // a tick can wait behind a whole open page, so pace each row early enough
  // that the late refresh still lands inside the interval
  localparam int REF_CYC     = (T_REFRESH_NS / CLK_PERIOD_NS - RAS_MAX_CYC -
                                RP_CYC - RAS_CYC - 2) / ROW_COUNT;
  localparam int ACC_CYC     = (CAC_CYC + SYNC_STAGES > RAS_CYC) ?
                               CAC_CYC + SYNC_STAGES : RAS_CYC;
  localparam int PAGE_LIMIT  = RAS_MAX_CYC - ACC_CYC - CP_CYC - 2;

  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_ROW  = 8'h02,
    S_RCD  = 8'h04,
    S_CAS  = 8'h08,
    S_ACC  = 8'h10,
    S_PAGE = 8'h20,
    S_PRE  = 8'h40,
    S_REF  = 8'h80
  } state_t;

  typedef struct packed {
    logic              write;
    logic              sel;
    logic [ADDR_W-1:0] addr;
    logic              wdata;
  } req_t;

  typedef struct packed {
    logic             ras_n;
    logic             cas_n;
    logic             write_n;
    logic             cs_n;
    logic [ROW_W-1:0] addr;
    logic             din;
  } pins_t;

  localparam pins_t PINS_IDLE = '{ras_n: 1'b1, cas_n: 1'b1, write_n: 1'b1,
                                  cs_n: 1'b1, addr: '0, din: 1'b0};

endpackage

// ==== rtl/bit_sync.sv ====
`timescale 1ns/10ps
module bit_sync #(
  parameter int STAGES = 2
) (
  input  wire logic core_clk_in,
  input  wire logic rst_n_in,
  input  wire logic bit_in,
  output logic      bit_out
);
  logic [STAGES-1:0] chain_reg;

  if (STAGES < 2) begin : g_chk
    $error("bit_sync needs at least two stages");
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      chain_reg <= '0;
    end else begin
      chain_reg <= {chain_reg[STAGES-2:0], bit_in};
    end
  end

  assign bit_out = chain_reg[STAGES-1];
endmodule // bit_sync

// ==== rtl/dram_host_ctl.sv ====
`timescale 1ns/10ps
// Summary of operation
// R01: cas fall forces device output open
// R02: selected read drives stored bit after access
// R03: early write echoes written bit on output
// R04: driven output holds until next cas fall
// R05: cas without ras leaves output open
// R06: deselected cycle keeps output open
// R07: deselected cycle ignores write
// R08: ras-only refresh keeps output, may drift
// R09: first cas cycle restores output
// R10: every row cycled within 2 ms
// R11: any ras cycle refreshes its row
// R12: refresh cycles keep chip deselected
// R13: cas without ras means unselected
// R14: refresh holds cas high or deselects
// R15: cas goes to chip every cycle
// R16: page mode holds ras, new columns
// R17: chip select judged per page cycle
// R18: eight refresh cycles before first access
// R19: ras latches row, cas column and select
// R20: data in captured at later strobe
// R21: six-bit refresh row counter wraps
module dram_host_ctl
  import dram_ctl_pkg::*;
#(
  parameter int INIT_CYCLES = INIT_REFRESH
) (
  input  wire logic  core_clk_in,
  input  wire logic  rst_n_in,
  input  wire logic  req_valid_in,
  input  wire req_t  req_in,
  input  wire logic  page_en_in,
  input  wire logic  dout_in,
  output logic       req_ack_out,
  output logic       done_out,
  output logic       rdata_out,
  output logic       init_done_out,
  output pins_t      pins_out
);

  if (INIT_CYCLES < 1 || INIT_CYCLES >= (1 << INIT_W)) begin : g_chk
    $error("INIT_CYCLES out of range");
  end

  typedef struct packed {
    state_t            state;
    logic [CNT_W-1:0]  cnt;
    logic [CNT_W-1:0]  page_cnt;
    logic [TMR_W-1:0]  ref_timer;
    logic              ref_pending;
    logic              is_ref;
    logic [ROW_W-1:0]  ref_row;
    logic [ROW_W-1:0]  open_row;
    logic [INIT_W-1:0] init_cnt;
    logic              init_done;
    req_t              req;
    logic              ack;
    logic              done;
    logic              rdata;
    pins_t             pins;
  } ctl_t;

  ctl_t r_reg;
  ctl_t r_next;
  logic dout_sync;

  // device output is unclocked to us, so it is synchronised first
  bit_sync #(
    .STAGES (SYNC_STAGES)
  ) bit_sync_inst (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .bit_in      (dout_in),
    .bit_out     (dout_sync)
  );

  logic row_hit;
  assign row_hit = (req_in.addr[ADDR_W-1:COL_W] == r_reg.open_row);

  always_comb begin
    r_next      = r_reg;
    r_next.ack  = 1'b0;
    r_next.done = 1'b0;
    r_next.cnt  = r_reg.cnt + 9'h1;
    if (r_reg.pins.ras_n) begin
      r_next.page_cnt = '0;
    end else begin
      r_next.page_cnt = r_reg.page_cnt + 9'h1;
    end

    // refresh pacing; a tick in the same cycle as a clear wins
    if (r_reg.ref_timer == TMR_W'(REF_CYC - 1)) begin // [R10]
      r_next.ref_timer   = '0;
      r_next.ref_pending = 1'b1;
    end else begin
      r_next.ref_timer = r_reg.ref_timer + 11'h1;
    end

    unique case (r_reg.state)
      S_IDLE: begin
        r_next.pins = PINS_IDLE;
        r_next.cnt  = '0;
        if (r_reg.ref_pending || !r_reg.init_done) begin // [R18]
          r_next.is_ref    = 1'b1;
          r_next.pins.addr = r_reg.ref_row; // [R21]
          r_next.state     = S_ROW;
          if (r_next.ref_timer != '0) begin
            r_next.ref_pending = 1'b0;
          end
        end else if (req_valid_in) begin
          r_next.is_ref    = 1'b0;
          r_next.req       = req_in;
          r_next.ack       = 1'b1;
          r_next.open_row  = req_in.addr[ADDR_W-1:COL_W];
          r_next.pins.addr = req_in.addr[ADDR_W-1:COL_W]; // [R19]
          r_next.state     = S_ROW;
        end
      end
      S_ROW: begin
        // row address already stable for one cycle before the fall
        r_next.pins.ras_n = 1'b0; // [R19] [R11]
        r_next.cnt        = '0;
        r_next.state      = r_reg.is_ref ? S_REF : S_RCD;
      end
      S_REF: begin
        // ras-only: cas and select stay high, no output contention
        r_next.pins.cas_n = 1'b1; // [R14] [R12]
        r_next.pins.cs_n  = 1'b1; // [R12]
        if (r_reg.cnt == CNT_W'(RAS_CYC - 1)) begin
          r_next.pins.ras_n = 1'b1;
          r_next.ref_row    = r_reg.ref_row + 6'h1; // [R21]
          if (!r_reg.init_done) begin
            r_next.init_cnt = r_reg.init_cnt + 4'h1;
            r_next.init_done =
              (r_reg.init_cnt == INIT_W'(INIT_CYCLES - 1)); // [R18]
          end
          r_next.cnt   = '0;
          r_next.state = S_PRE;
        end
      end
      S_RCD: begin
        if (r_reg.cnt == CNT_W'(RCD_CYC - 1)) begin
          r_next.pins.addr    = r_reg.req.addr[COL_W-1:0]; // [R19]
          r_next.pins.cs_n    = !r_reg.req.sel; // [R17]
          // early write: write low and data set before cas falls
          r_next.pins.write_n = !r_reg.req.write; // [R03] [R20]
          r_next.pins.din     = r_reg.req.wdata; // [R20]
          r_next.state        = S_CAS;
        end
      end
      S_CAS: begin
        r_next.pins.cas_n = 1'b0; // [R15] [R16]
        r_next.cnt        = '0;
        r_next.state      = S_ACC;
      end
      S_ACC: begin
        if (r_reg.cnt == CNT_W'(ACC_CYC - 1)) begin
          // output stays driven past cas rise, sample before release
          r_next.rdata        = r_reg.req.write ? r_reg.req.wdata
                                                : dout_sync; // [R02] [R04]
          r_next.done         = 1'b1;
          r_next.pins.cas_n   = 1'b1;
          r_next.pins.write_n = 1'b1;
          r_next.cnt          = '0;
          r_next.state        = S_PAGE;
        end
      end
      S_PAGE: begin
        if (r_reg.cnt >= CNT_W'(CP_CYC - 1)) begin
          r_next.cnt = r_reg.cnt;
          if (r_reg.ref_pending || !page_en_in ||
              r_reg.page_cnt >= CNT_W'(PAGE_LIMIT) ||
              (req_valid_in && !row_hit)) begin
            r_next.pins.ras_n = 1'b1;
            r_next.cnt        = '0;
            r_next.state      = S_PRE;
          end else if (req_valid_in) begin
            // same row: new column only, ras stays low
            r_next.req          = req_in; // [R16]
            r_next.ack          = 1'b1;
            r_next.pins.addr    = req_in.addr[COL_W-1:0];
            r_next.pins.cs_n    = !req_in.sel; // [R17]
            r_next.pins.write_n = !req_in.write; // [R03]
            r_next.pins.din     = req_in.wdata; // [R20]
            r_next.state        = S_CAS;
          end
        end
      end
      S_PRE: begin
        if (r_reg.cnt == CNT_W'(RP_CYC - 1)) begin
          r_next.state = S_IDLE;
        end
      end
      default: begin
        r_next.pins  = PINS_IDLE;
        r_next.state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      r_reg       <= '0;
      r_reg.state <= S_IDLE;
      r_reg.pins  <= PINS_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign req_ack_out   = r_reg.ack;
  assign done_out      = r_reg.done;
  assign rdata_out     = r_reg.rdata;
  assign init_done_out = r_reg.init_done;
  assign pins_out      = r_reg.pins;

  // helper: cycles since the last refresh row was closed
  logic [TMR_W+1:0] gap_reg;
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || r_reg.state == S_REF) begin
      gap_reg <= '0;
    end else begin
      gap_reg <= gap_reg + 13'h1;
    end
  end

  localparam int GAP_MAX = REF_CYC + RAS_MAX_CYC + RP_CYC + RAS_CYC + 8;

  ref_gap_a: assert property ( // [R10]
    @(posedge core_clk_in) disable iff (!rst_n_in)
    gap_reg <= GAP_MAX)
    else $error("refresh interval exceeded");

  ref_strobes_a: assert property ( // [R14]
    @(posedge core_clk_in) disable iff (!rst_n_in)
    r_reg.state == S_REF |-> r_reg.pins.cas_n && !r_reg.pins.ras_n)
    else $error("cas active during refresh");

  ref_deselect_a: assert property ( // [R12]
    @(posedge core_clk_in) disable iff (!rst_n_in)
    r_reg.state == S_REF |-> r_reg.pins.cs_n && r_reg.pins.write_n)
    else $error("chip selected during refresh");

  row_stable_a: assert property ( // [R19]
    @(posedge core_clk_in) disable iff (!rst_n_in)
    $fell(r_reg.pins.ras_n) |-> $stable(r_reg.pins.addr))
    else $error("row address moved at ras fall");

  cas_with_ras_a: assert property ( // [R16]
    @(posedge core_clk_in) disable iff (!rst_n_in)
    $fell(r_reg.pins.cas_n) |-> !r_reg.pins.ras_n && !$past(r_reg.pins.ras_n))
    else $error("cas fell without ras held low");

  select_setup_a: assert property ( // [R17]
    @(posedge core_clk_in) disable iff (!rst_n_in)
    $fell(r_reg.pins.cas_n) |->
      $stable(r_reg.pins.cs_n) && $stable(r_reg.pins.addr) &&
      $stable(r_reg.pins.din) && $stable(r_reg.pins.write_n))
    else $error("column inputs moved at cas fall");

  data_hold_a: assert property ( // [R20]
    @(posedge core_clk_in) disable iff (!rst_n_in)
    !r_reg.pins.cas_n && !r_reg.pins.write_n |=> $stable(r_reg.pins.din))
    else $error("data in changed during write strobe");

  row_step_a: assert property ( // [R21]
    @(posedge core_clk_in) disable iff (!rst_n_in)
    r_reg.state == S_REF && r_next.state == S_PRE |=>
      r_reg.ref_row == $past(r_reg.ref_row) + 6'h1)
    else $error("refresh row did not advance");

  init_first_a: assert property ( // [R18]
    @(posedge core_clk_in) disable iff (!rst_n_in)
    r_reg.ack |-> r_reg.init_done && r_reg.init_cnt == INIT_W'(INIT_CYCLES))
    else $error("access before power-up refreshes");

endmodule // dram_host_ctl

// ==== test/dram_dev_model.sv ====
`timescale 1ns/10ps
module dram_dev_model
  import dram_ctl_pkg::*;
#(
  parameter int ACC_NS = T_CAC_NS
) (
  input  wire pins_t pins_in,
  output logic       dout_out,
  output logic       drv_out
);
  logic              mem [4096];
  logic [ROW_W-1:0]  row;
  logic [ADDR_W-1:0] a;
  logic              sel;
  logic              last;

  initial begin
    drv_out = 1'b0;
    last = 1'b0;
    sel = 1'b0;
  end

  // no pull on the pin: released output shows the inverse of the last bit
  assign dout_out = drv_out ? last : ~last;

  // ras-only cycles never touch the output
  always @(negedge pins_in.ras_n) row = pins_in.addr;

  // one access in flight: a second cas fall inside ACC_NS would be missed
  always @(negedge pins_in.cas_n) begin
    drv_out = 1'b0;
    sel = !pins_in.ras_n && !pins_in.cs_n;
    a = {row, pins_in.addr};
    if (sel && !pins_in.write_n) mem[a] = pins_in.din;
    if (sel) begin
      #(ACC_NS);
      last = mem[a];
      drv_out = 1'b1;
    end
  end

  always @(negedge pins_in.write_n) begin
    if (sel && !pins_in.cas_n && !pins_in.ras_n) mem[a] = pins_in.din;
  end
endmodule // dram_dev_model

// ==== test/dram_output_refresh_page_control_tb.sv ====
`timescale 1ns/10ps
module dram_output_refresh_page_control_tb
  import dram_ctl_pkg::*;
;
  logic       core_clk_in;
  logic       rst_n_in;
  logic       req_valid_in;
  req_t       req_in;
  logic       page_en_in;
  logic       dout_in;
  logic       req_ack_out;
  logic       done_out;
  logic       rdata_out;
  logic       init_done_out;
  pins_t      pins_out;
  logic       drv;
  logic       cas_seen;
  logic [5:0] ras_row;
  logic [5:0] ref_last;
  int         error_cnt;
  int         n_tests;
  int         cas_cnt;
  int         ras_falls;
  int         ref_n;
  int         ref_gap;
  time        ref_t;

  dram_host_ctl dram_host_ctl_inst (
    .core_clk_in   (core_clk_in),
    .rst_n_in      (rst_n_in),
    .req_valid_in  (req_valid_in),
    .req_in        (req_in),
    .page_en_in    (page_en_in),
    .dout_in       (dout_in),
    .req_ack_out   (req_ack_out),
    .done_out      (done_out),
    .rdata_out     (rdata_out),
    .init_done_out (init_done_out),
    .pins_out      (pins_out)
  );

  dram_dev_model dram_dev_model_inst (
    .pins_in  (pins_out),
    .dout_out (dout_in),
    .drv_out  (drv)
  );

  task automatic chk(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_n(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: count %0d, expected %0d", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d, errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic tmo;
    error_cnt++;
    $display("wrong value at %0t: wait ran out", $time);
    final_report;
  endtask

  task automatic acc(input logic w, s, input logic [11:0] a, input logic d, e);
    int k;
    @(negedge core_clk_in);
    req_in = '{write: w, sel: s, addr: a, wdata: d};
    req_valid_in = 1'b1;
    for (k = 0; k < 3000 && req_ack_out !== 1'b1; k++) @(negedge core_clk_in);
    if (req_ack_out !== 1'b1) tmo;
    req_valid_in = 1'b0;
    for (k = 0; k < 40 && done_out !== 1'b1; k++) @(negedge core_clk_in);
    if (done_out !== 1'b1) tmo;
    if (s) chk(rdata_out, e);
    chk(drv, s);
    if (s) chk(dout_in, e);
  endtask

  // refresh cycles are the ras pulses that saw no cas fall
  always @(negedge pins_out.ras_n) begin
    cas_seen = 1'b0;
    ras_row = pins_out.addr;
    ras_falls++;
  end
  always @(negedge pins_out.cas_n) begin
    cas_seen = 1'b1;
    cas_cnt++;
  end
  always @(posedge pins_out.ras_n) begin
    if (rst_n_in === 1'b1 && cas_seen === 1'b0) begin
      chk(pins_out.cs_n, 1'b1);
      if (ref_n > 0) chk_n(ras_row, 6'(ref_last + 6'h01));
      ref_gap = int'(($time - ref_t) / CLK_PERIOD_NS);
      ref_t = $time;
      ref_last = ras_row;
      ref_n++;
    end
  end

  task automatic t_init;
    int k;
    for (k = 0; k < 2000 && init_done_out !== 1'b1; k++)
      @(negedge core_clk_in);
    if (init_done_out !== 1'b1) tmo;
    chk(init_done_out, 1'b1);
    chk(ref_n >= INIT_REFRESH, 1'b1);
    chk_n(cas_cnt, 0);
  endtask

  task automatic t_rw;
    logic [11:0] a [4] = '{12'h000, 12'hfff, 12'h5a3, 12'ha5c};
    int i;
    for (i = 0; i < 4; i++) acc(1'b1, 1'b1, a[i], ~i[0], ~i[0]);
    for (i = 0; i < 4; i++) acc(1'b0, 1'b1, a[i], 1'b0, ~i[0]);
  endtask

  task automatic t_desel;
    acc(1'b1, 1'b0, 12'h5a3, 1'b0, 1'b0);
    chk(drv, 1'b0);
    acc(1'b0, 1'b1, 12'h5a3, 1'b0, 1'b1);
  endtask

  // starts just after a refresh so no refresh tick splits the page
  task automatic t_page;
    int k, r;
    k = ref_n;
    for (r = 0; r < 1400 && ref_n == k; r++) @(negedge core_clk_in);
    if (ref_n == k) tmo;
    page_en_in = 1'b1;
    r = ras_falls;
    acc(1'b1, 1'b0, 12'h4c0, 1'b1, 1'b0);
    acc(1'b1, 1'b1, 12'h4c0, 1'b0, 1'b0);
    acc(1'b1, 1'b1, 12'h4ff, 1'b1, 1'b1);
    acc(1'b1, 1'b0, 12'h4c0, 1'b1, 1'b0);
    acc(1'b0, 1'b1, 12'h4c0, 1'b0, 1'b0);
    acc(1'b0, 1'b1, 12'h4ff, 1'b0, 1'b1);
    chk_n(ras_falls - r, 1);
    page_en_in = 1'b0;
  endtask

  task automatic t_ref;
    int k, r;
    acc(1'b0, 1'b1, 12'hfff, 1'b0, 1'b0);
    k = ref_n;
    for (r = 0; r < 3000 && ref_n < k + 2; r++) @(negedge core_clk_in);
    if (ref_n < k + 2) tmo;
    chk(drv, 1'b1);
    chk(dout_in, 1'b0);
    chk(ref_gap <= REF_CYC + 40, 1'b1);
  endtask

  initial begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end

  initial begin
    rst_n_in = 1'b0;
    req_valid_in = 1'b0;
    req_in = '0;
    page_en_in = 1'b0;
    {error_cnt, n_tests, cas_cnt, ras_falls, ref_n, ref_gap} = '0;
    cas_seen = 1'b1;
    ref_t = 0;
    ref_last = 6'h00;
    repeat (5) @(negedge core_clk_in);
    rst_n_in = 1'b1;
    t_init;
    t_rw;
    t_desel;
    t_page;
    t_ref;
    final_report;
  end
endmodule // dram_output_refresh_page_control_tb
